// ---- design/mxt_cfg.svh ----
// constants for the extended-type register access block
`ifndef MXT_CFG_SVH
`define MXT_CFG_SVH
`define MXT_TYPE_MSB       15
`define MXT_TYPE_LSB       14
`define MXT_INDEX_BITS     14
`define MXT_EXC_ILL_FUNC   8'h01
`define MXT_EXC_ILL_ADDR   8'h02
`define MXT_FC_ERR_BIT     7
`define MXT_MAX_REGS       16'h007d
`endif

// ---- design/mxt_pkg.sv ----
// types for the extended-type register access block
package mxt_pkg;
    typedef enum logic [1:0] {
        MXT_TYPE_INT16 = 2'b00,
        MXT_TYPE_INT32 = 2'b01,
        MXT_TYPE_FLT32 = 2'b10,
        MXT_TYPE_RSVD  = 2'b11
    } mxt_type_e;

    typedef enum logic [2:0] {
        MXT_ST_IDLE  = 3'b000,
        MXT_ST_FETCH = 3'b001,
        MXT_ST_WAIT  = 3'b010,
        MXT_ST_EMIT  = 3'b011,
        MXT_ST_DONE  = 3'b100
    } mxt_state_e;
endpackage

// ---- design/mxt_value_fmt.sv ----
// value formatting between parameter width and selected access width
`timescale 1ns/1ps
`include "mxt_cfg.svh"
module mxt_value_fmt
    import mxt_pkg::*;
(
    // read path
    input  wire logic [31:0] par_value_i,
    input  wire logic        par_is32_i,
    input  wire logic        acc32_i,
    output logic      [31:0] rd_value_o,
    // write path
    input  wire logic [31:0] wr_value_i,
    output logic      [31:0] wr_value_o,
    output logic             wr_fits16_o
);
    wire [31:0] low_sext = {{16{par_value_i[15]}}, par_value_i[15:0]};
    // 32-bit access sign-extends a 16-bit parameter; 16-bit access keeps the low word
    assign rd_value_o = (acc32_i && !par_is32_i) ? low_sext :
                        acc32_i ? par_value_i : {16'h0000, par_value_i[15:0]};
    // a 16-bit write widens by sign; a 32-bit write passes unchanged
    assign wr_value_o = acc32_i ? wr_value_i :
                        {{16{wr_value_i[15]}}, wr_value_i[15:0]};
    // range check for a wide value landing on a narrow parameter
    assign wr_fits16_o = (wr_value_o[31:15] == 17'h00000) ||
                         (wr_value_o[31:15] == 17'h1ffff);
endmodule

// ---- design/mxt_access.sv ----
// register access engine: type decode, block walk, packing and exceptions
// Behaviour
// - 32-bit values only via multiple-register services
// - one register per parameter, index X*100+Y-1
// - top two address bits select data type
// - 00 int16, 01 int32, 10 float, 11 reserved
// - type from start address holds whole block
// - 32-bit values sent high word first
// - 16-bit read of 32-bit parameter returns low word
// - 32-bit read of 16-bit parameter sign-extends
// - odd count in 32-bit access gives exception 2
// - byte count is two per register
// - exception carries function code with bit 7 set
// - 16-bit write to 32-bit parameter sign-extends
// - 32-bit write to 16-bit parameter if in range
`timescale 1ns/1ps
`include "mxt_cfg.svh"
module mxt_access
    import mxt_pkg::*;
#(
    parameter bit FLOAT_SUPPORT = 1'b1,
    parameter int MAX_REGS      = 125
)
(
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // request from frame handling
    input  wire logic        req_valid_i,
    input  wire logic [7:0]  req_func_i,
    input  wire logic        req_write_i,
    input  wire logic [15:0] req_start_i,
    input  wire logic [15:0] req_count_i,
    // write data, one 16-bit register per strobe
    input  wire logic        wr_reg_valid_i,
    input  wire logic [15:0] wr_reg_data_i,
    // parameter store port
    output logic             par_rd_o,
    output logic             par_wr_o,
    output logic [13:0]      par_index_o,
    output logic [31:0]      par_wdata_o,
    input  wire logic        par_ack_i,
    input  wire logic [31:0] par_rdata_i,
    input  wire logic        par_is32_i,
    // answer toward frame handling
    output logic             rsp_start_o,
    output logic [7:0]       rsp_func_o,
    output logic [7:0]       rsp_bytes_o,
    output logic             rsp_word_valid_o,
    output logic [15:0]      rsp_word_o,
    output logic             rsp_exc_o,
    output logic [7:0]       rsp_exc_code_o,
    output logic             rsp_done_o,
    output logic             rsp_range_err_o
);
    // ******************************
    // request decode
    // ******************************
    function automatic logic is_wide(input mxt_type_e t);
        is_wide = (t == MXT_TYPE_INT32) || (t == MXT_TYPE_FLT32);
    endfunction

    wire mxt_type_e req_type  = mxt_type_e'(req_start_i[`MXT_TYPE_MSB:`MXT_TYPE_LSB]);
    wire            req_wide  = is_wide(req_type);
    wire            bad_type  = (req_type == MXT_TYPE_RSVD) ||
                                (req_type == MXT_TYPE_FLT32 && !FLOAT_SUPPORT);
    wire            odd_wide  = req_wide && req_count_i[0];
    wire            cnt_bad   = (req_count_i == 16'h0000) ||
                                (req_count_i > 16'(MAX_REGS));
    wire            reject    = bad_type || odd_wide || cnt_bad;
    wire [15:0]     req_pars  = req_wide ? {1'b0, req_count_i[15:1]} : req_count_i;

    // ******************************
    // state
    // ******************************
    mxt_state_e  state_reg, state_next;
    logic        wide_reg;
    logic        write_reg;
    logic [13:0] index_reg;
    logic [15:0] left_reg;
    logic [31:0] value_reg;
    logic        half_reg;
    logic        hi_pending_reg;
    logic [15:0] hi_word_reg;
    logic [7:0]  func_reg;

    // formatted read value and widened write value
    wire [31:0] fmt_rd;
    wire [31:0] fmt_wr;
    wire        fits16;
    wire [31:0] wr_raw = wide_reg ? {hi_word_reg, wr_reg_data_i} :
                                    {16'h0000, wr_reg_data_i};

    mxt_value_fmt u_fmt (
        .par_value_i (par_rdata_i),
        .par_is32_i  (par_is32_i),
        .acc32_i     (wide_reg),
        .rd_value_o  (fmt_rd),
        .wr_value_i  (wr_raw),
        .wr_value_o  (fmt_wr),
        .wr_fits16_o (fits16)
    );

    // a write word completes a parameter on the low word of a wide pair
    wire wr_word_last = !wide_reg || hi_pending_reg;
    wire wr_take      = (state_reg == MXT_ST_FETCH) && write_reg && wr_reg_valid_i;
    wire wr_commit    = wr_take && wr_word_last;
    // narrow parameter refuses a wide value out of its range
    wire wr_refuse    = wr_commit && !par_is32_i && !fits16;
    wire last_par     = (left_reg == 16'h0001);

    // ******************************
    // sequencing
    // ******************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MXT_ST_IDLE:  if (req_valid_i) state_next = reject ? MXT_ST_DONE : MXT_ST_FETCH;
            MXT_ST_FETCH: begin
                if (!write_reg) begin
                    state_next = MXT_ST_WAIT;
                end else if (wr_refuse || (wr_commit && last_par)) begin
                    state_next = MXT_ST_DONE;
                end
            end
            MXT_ST_WAIT:  if (par_ack_i) state_next = MXT_ST_EMIT;
            MXT_ST_EMIT: begin
                if (!wide_reg || half_reg) begin
                    state_next = last_par ? MXT_ST_DONE : MXT_ST_FETCH;
                end
            end
            MXT_ST_DONE:  state_next = MXT_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= MXT_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // request context, latched once so the block keeps one type
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wide_reg  <= 1'b0;
            write_reg <= 1'b0;
            func_reg  <= 8'h00;
        end else if (state_reg == MXT_ST_IDLE && req_valid_i) begin
            wide_reg  <= req_wide;
            write_reg <= req_write_i;
            func_reg  <= req_func_i;
        end
    end

    // parameter walk: one index per parameter whatever the width
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            index_reg <= 14'h0000;
            left_reg  <= 16'h0000;
        end else if (state_reg == MXT_ST_IDLE && req_valid_i) begin
            index_reg <= req_start_i[`MXT_INDEX_BITS-1:0];
            left_reg  <= req_pars;
        end else if (wr_commit ||
                     (state_reg == MXT_ST_EMIT && (!wide_reg || half_reg))) begin
            index_reg <= index_reg + 14'h0001;
            left_reg  <= left_reg - 16'h0001;
        end
    end

    // high word of a wide write waits for its low word
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_pending_reg <= 1'b0;
            hi_word_reg    <= 16'h0000;
        end else if (state_reg == MXT_ST_IDLE) begin
            hi_pending_reg <= 1'b0;
        end else if (wr_take && wide_reg) begin
            hi_pending_reg <= !hi_pending_reg;
            hi_word_reg    <= wr_reg_data_i;
        end
    end

    // read value capture and half select
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_reg <= 32'h00000000;
            half_reg  <= 1'b0;
        end else if (state_reg == MXT_ST_WAIT && par_ack_i) begin
            value_reg <= fmt_rd;
            half_reg  <= 1'b0;
        end else if (state_reg == MXT_ST_EMIT) begin
            half_reg  <= !half_reg;
        end
    end

    // ******************************
    // store port
    // ******************************
    wire rd_issue = (state_reg == MXT_ST_FETCH) && !write_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            par_rd_o    <= 1'b0;
            par_wr_o    <= 1'b0;
            par_index_o <= 14'h0000;
            par_wdata_o <= 32'h00000000;
        end else begin
            par_rd_o    <= rd_issue;
            par_wr_o    <= wr_commit && !wr_refuse;
            par_index_o <= index_reg;
            par_wdata_o <= fmt_wr;
        end
    end

    // ******************************
    // answer
    // ******************************
    // big-endian: upper half goes out first on wide access
    wire [15:0] emit_word = (wide_reg && !half_reg) ? value_reg[31:16] : value_reg[15:0];
    wire [15:0] byte_cnt  = {req_count_i[14:0], 1'b0};
    wire        start_ok  = (state_reg == MXT_ST_IDLE) && req_valid_i && !reject;
    wire        start_bad = (state_reg == MXT_ST_IDLE) && req_valid_i && reject;
    wire [7:0]  exc_func  = req_func_i | 8'(1 << `MXT_FC_ERR_BIT);

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_start_o      <= 1'b0;
            rsp_func_o       <= 8'h00;
            rsp_bytes_o      <= 8'h00;
            rsp_word_valid_o <= 1'b0;
            rsp_word_o       <= 16'h0000;
            rsp_exc_o        <= 1'b0;
            rsp_exc_code_o   <= 8'h00;
            rsp_done_o       <= 1'b0;
            rsp_range_err_o  <= 1'b0;
        end else begin
            rsp_start_o      <= start_ok;
            rsp_exc_o        <= start_bad;
            rsp_word_valid_o <= (state_reg == MXT_ST_EMIT);
            rsp_word_o       <= emit_word;
            rsp_done_o       <= (state_next == MXT_ST_DONE) && (state_reg != MXT_ST_DONE);
            rsp_range_err_o  <= wr_refuse;
            if (start_ok) begin
                rsp_func_o  <= req_func_i;
                rsp_bytes_o <= req_write_i ? 8'h00 : byte_cnt[7:0];
            end
            if (start_bad) begin
                rsp_func_o     <= exc_func;
                rsp_exc_code_o <= `MXT_EXC_ILL_ADDR;
            end
        end
    end
endmodule

// ---- tb/mxt_access_chk.sv ----
// assertion checker for the extended-type access engine
`timescale 1ns/1ps
module mxt_access_chk
    import mxt_pkg::*;
(
    // request side
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    input wire logic        req_valid_i,
    input wire logic        req_write_i,
    input wire logic [15:0] req_start_i,
    input wire logic [15:0] req_count_i,
    // store and answer side
    input wire logic        par_rd_o,
    input wire logic [13:0] par_index_o,
    input wire logic        par_ack_i,
    input wire logic        rsp_start_o,
    input wire logic [7:0]  rsp_func_o,
    input wire logic [7:0]  rsp_bytes_o,
    input wire logic        rsp_word_valid_o,
    input wire logic        rsp_exc_o,
    input wire logic [7:0]  rsp_exc_code_o,
    input wire logic        rsp_done_o
);
    logic        idle_reg;
    logic [32:0] req_reg;
    logic [15:0] nw_reg;
    logic        take;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // a request counts only while the engine is idle
    assign take = req_valid_i && idle_reg;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idle_reg <= 1'b1;
        end else begin
            idle_reg <= take ? 1'b0 : (rsp_done_o | idle_reg);
        end
    end
    always_ff @(posedge mclk_i) begin
        if (take) begin
            req_reg <= {req_write_i, req_start_i, req_count_i};
        end
        nw_reg <= take ? 16'h0000 : nw_reg + {15'h0000, rsp_word_valid_o};
    end
    property p_odd;
        take && req_start_i[15:14] == 2'b01 && req_count_i[0] |=> rsp_exc_o && rsp_exc_code_o == 8'h02;
    endproperty
    a_odd: assert property (p_odd) else $error("odd count not refused");
    property p_rsvd;
        take && req_start_i[15:14] == 2'b11 |=> rsp_exc_o && rsp_done_o;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved type served");
    property p_func;
        rsp_exc_o |-> rsp_func_o[7];
    endproperty
    a_func: assert property (p_func) else $error("error bit clear");
    property p_bytes;
        rsp_start_o && !req_reg[32] |-> rsp_bytes_o == {req_reg[6:0], 1'b0};
    endproperty
    a_bytes: assert property (p_bytes) else $error("byte count");
    property p_idx;
        rsp_start_o && !req_reg[32] |=> par_rd_o && par_index_o == req_reg[29:16];
    endproperty
    a_idx: assert property (p_idx) else $error("first index");
    property p_word;
        par_ack_i |-> ##2 rsp_word_valid_o;
    endproperty
    a_word: assert property (p_word) else $error("word late");
    property p_nodata;
        rsp_exc_o |-> !rsp_word_valid_o && !rsp_start_o ##1 !par_rd_o [*2];
    endproperty
    a_nodata: assert property (p_nodata) else $error("data after refusal");
    property p_cnt;
        rsp_done_o && !rsp_exc_o && !req_reg[32] |-> nw_reg + rsp_word_valid_o == req_reg[15:0];
    endproperty
    a_cnt: assert property (p_cnt) else $error("word count");
    c_exc: cover property (rsp_exc_o);
    c_pair: cover property (rsp_word_valid_o ##[1:8] rsp_word_valid_o);
    c_done: cover property (rsp_done_o && !rsp_exc_o);
endmodule

// ---- tb/mxt_store_model.sv ----
// parameter store model answering the access engine
`timescale 1ns/1ps
module mxt_store_model (
    // engine side
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,
    input  wire logic        par_rd_i,
    input  wire logic        par_wr_i,
    input  wire logic [13:0] par_index_i,
    input  wire logic [31:0] par_wdata_i,
    // answer
    output logic             par_ack_o,
    output logic [31:0]      par_rdata_o,
    output logic             par_is32_o
);
    logic [31:0] mem_reg [8];
    logic [2:0]  ix_reg;
    logic [1:0]  cnt_reg;
    logic        pend_reg;
    initial mem_reg = '{0: 32'h12345678, 1: 32'h0000abcd, 2: 32'h00000123, default: 32'h0};
    // only entry 0 is a wide parameter
    assign par_is32_o = (par_index_i[2:0] == 3'h0);
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {pend_reg, par_ack_o, par_rdata_o} <= 34'h0;
        end else begin
            par_ack_o <= 1'b0;
            if (par_wr_i) mem_reg[par_index_i[2:0]] <= par_wdata_i;
            if (par_rd_i) begin
                {pend_reg, ix_reg, cnt_reg} <= {1'b1, par_index_i[2:0], slow_i ? 2'h3 : 2'h0};
            end else if (pend_reg && cnt_reg == 2'h0) begin
                {pend_reg, par_ack_o, par_rdata_o} <= {2'b01, mem_reg[ix_reg]};
            end else begin
                // data is not held outside the answer cycle
                par_rdata_o <= ~par_rdata_o;
                cnt_reg <= cnt_reg - {1'b0, pend_reg};
            end
        end
    end
endmodule

// ---- tb/tb_mxt_access.sv ----
// self-checking testbench for the extended-type access engine
`timescale 1ns/1ps
module tb_mxt_access;
    typedef struct packed {logic [15:0] st; logic [15:0] cnt; logic exc; logic [63:0] w;} mxt_row_s;
    logic        mclk_i, rst_n_i, req_valid_i, req_write_i, wr_reg_valid_i, slow, dv, ev;
    logic        par_rd_o, par_wr_o, par_ack_i, par_is32_i, rsp_start_o, rsp_word_valid_o;
    logic        rsp_exc_o, rsp_done_o, rsp_range_err_o;
    logic [7:0]  req_func_i, rsp_func_o, rsp_bytes_o, rsp_exc_code_o;
    logic [13:0] par_index_o;
    logic [15:0] req_start_i, req_count_i, wr_reg_data_i, rsp_word_o;
    logic [31:0] par_rdata_i, par_wdata_o, wv;
    int          mismatches, n_tests;
    mxt_row_s    rows [10];
    mxt_access u_dut (.mclk_i, .rst_n_i, .req_valid_i, .req_func_i, .req_write_i, .req_start_i,
        .req_count_i, .wr_reg_valid_i, .wr_reg_data_i, .par_rd_o, .par_wr_o, .par_index_o,
        .par_wdata_o, .par_ack_i, .par_rdata_i, .par_is32_i, .rsp_start_o, .rsp_func_o,
        .rsp_bytes_o, .rsp_word_valid_o, .rsp_word_o, .rsp_exc_o, .rsp_exc_code_o,
        .rsp_done_o, .rsp_range_err_o);
    mxt_store_model u_store (.mclk_i, .rst_n_i, .slow_i(slow), .par_rd_i(par_rd_o),
        .par_wr_i(par_wr_o), .par_index_i(par_index_o), .par_wdata_i(par_wdata_o),
        .par_ack_o(par_ack_i), .par_rdata_o(par_rdata_i), .par_is32_o(par_is32_i));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    // write results are latched so no pulse is missed between tasks
    always @(negedge mclk_i) begin
        if (par_wr_o === 1'b1) wv = par_wdata_o;
        if (rsp_range_err_o === 1'b1) ev = 1'b1;
        if (rsp_done_o === 1'b1) dv = 1'b1;
    end
    task end_sim;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task req(input logic w, input logic [15:0] st, input logic [15:0] c);
        @(negedge mclk_i);
        {dv, ev, wv} = {2'b00, 32'h0};
        {req_valid_i, req_write_i, req_start_i, req_count_i} = {1'b1, w, st, c};
        req_func_i = w ? 8'h10 : 8'h03;
        @(negedge mclk_i);
        req_valid_i = 1'b0;
    endtask
    task rd(input mxt_row_s r);
        int k;
        int i;
        logic d;
        logic ex;
        {k, d, ex} = 0;
        req(1'b0, r.st, r.cnt);
        // start and refusal pulses stand in the cycle right after the request edge, and so does done for a refused request
        for (i = 0; i < 300 && !d; i++) begin
            d = (rsp_done_o === 1'b1);
            ex = ex | (rsp_exc_o === 1'b1);
            if (rsp_start_o === 1'b1) chk("bytes", {r.cnt[6:0], 1'b0}, rsp_bytes_o);
            if (rsp_exc_o === 1'b1) chk("exc", 16'h8302, {rsp_func_o, rsp_exc_code_o});
            if (rsp_word_valid_o === 1'b1) begin
                chk("word", r.w[63 - 16 * k -: 16], rsp_word_o);
                k++;
            end
            if (!d) @(negedge mclk_i);
        end
        if (!d) begin
            mismatches++;
            end_sim;
        end
        chk("words", r.exc ? 0 : r.cnt, k);
        chk("refused", r.exc, ex);
    endtask
    task wr(input logic [15:0] st, input logic [15:0] c, input logic [31:0] d);
        int i;
        req(1'b1, st, c);
        chk("start", 9'h100, {rsp_start_o, rsp_bytes_o});
        @(negedge mclk_i);
        {wr_reg_valid_i, wr_reg_data_i} = {1'b1, c[1] ? d[31:16] : d[15:0]};
        if (c[1]) begin
            @(negedge mclk_i);
            wr_reg_data_i = d[15:0];
        end
        @(negedge mclk_i);
        wr_reg_valid_i = 1'b0;
        for (i = 0; i < 300 && !dv; i++) @(negedge mclk_i);
        if (!dv) begin
            mismatches++;
            end_sim;
        end
    endtask
    initial begin
        {rst_n_i, req_valid_i, req_write_i, wr_reg_valid_i, slow, dv, ev} = 7'h0;
        {req_func_i, req_start_i, req_count_i, wr_reg_data_i} = 56'h0;
        {mismatches, n_tests} = 0;
        rows = '{'{16'h0000, 16'h1, 1'b0, 64'h5678_0000_0000_0000},
                 '{16'h4000, 16'h2, 1'b0, 64'h1234_5678_0000_0000},
                 '{16'h0001, 16'h1, 1'b0, 64'habcd_0000_0000_0000},
                 '{16'h4001, 16'h2, 1'b0, 64'hffff_abcd_0000_0000},
                 '{16'h4002, 16'h2, 1'b0, 64'h0000_0123_0000_0000},
                 '{16'h0000, 16'h2, 1'b0, 64'h5678_abcd_0000_0000},
                 '{16'h4000, 16'h4, 1'b0, 64'h1234_5678_ffff_abcd},
                 '{16'h4000, 16'h1, 1'b1, 64'h0},
                 '{16'h8000, 16'h3, 1'b1, 64'h0},
                 '{16'hc000, 16'h2, 1'b1, 64'h0}};
        repeat (10) @(negedge mclk_i);
        chk("reset", 0, {par_rd_o, par_wr_o, rsp_start_o, rsp_word_valid_o, rsp_exc_o, rsp_done_o});
        rst_n_i = 1'b1;
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            slow = s[0];
            foreach (rows[i]) rd(rows[i]);
            $display("test reads done, slow store %0d", s);
        end
        wr(16'h0000, 16'h1, 32'h0000abcd);
        chk("wdata", 32'hffffabcd, wv);
        wr(16'h0000, 16'h1, 32'h00001234);
        chk("wdata", 32'h00001234, wv);
        wr(16'h4001, 16'h2, 32'h00000123);
        chk("wdata", 32'h00000123, wv);
        wr(16'h4001, 16'h2, 32'h00012345);
        chk("range", 32'h00000001, {31'h0, ev});
        chk("nowrite", 32'h00000000, wv);
        $display("test writes done");
        end_sim;
    end
endmodule
bind mxt_access mxt_access_chk u_chk (.mclk_i, .rst_n_i, .req_valid_i, .req_write_i,
    .req_start_i, .req_count_i, .par_rd_o, .par_index_o, .par_ack_i, .rsp_start_o, .rsp_func_o,
    .rsp_bytes_o, .rsp_word_valid_o, .rsp_exc_o, .rsp_exc_code_o, .rsp_done_o);
